// ===== rtl/bvi_fw_word.sv
// one firmware version word: type code over revision, zero when not fitted
`timescale 1ns/1ps
module bvi_fw_word #(
	parameter logic [15:0] FW_TYPE = 16'h0001,
	parameter logic [15:0] FW_REV  = 16'h0001
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        fitted,
	output logic      [31:0] word_r
);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			word_r <= bvi_pkg::WORD_RESET;
		end else if (fitted) begin
			word_r <= {FW_TYPE, FW_REV};
		end else begin
			word_r <= bvi_pkg::WORD_RESET;
		end
	end

endmodule

// ===== rtl/bvi_pkg.sv
// shared constants and types for the board version information bank
package bvi_pkg;

	// bus geometry
	localparam int ADDR_W = 20;
	localparam int DATA_W = 32;

	// register indices; byte address is four times the index
	localparam logic [ADDR_W-1:0] IDX_BASE_CARD_VERSION   = 20'h007DA;
	localparam logic [ADDR_W-1:0] IDX_EXT_MODULE_VERSION  = 20'h007DB;
	localparam logic [ADDR_W-1:0] IDX_FE_MODULE_VERSION   = 20'h007DC;
	localparam logic [ADDR_W-1:0] IDX_PRODUCTION_DATE     = 20'h007E4;
	localparam logic [ADDR_W-1:0] IDX_FACTORY_CAL_DATE    = 20'h007E9;
	localparam logic [ADDR_W-1:0] IDX_MAIN_CTRL_FW        = 20'h33450;
	localparam logic [ADDR_W-1:0] IDX_MAIN_CTRL_RECOV_FW  = 20'h33451;
	localparam logic [ADDR_W-1:0] IDX_BOOTED_IMAGE_INFO   = 20'h33452;
	localparam logic [ADDR_W-1:0] IDX_CLOCK_DIST_FW       = 20'h3345A;
	localparam logic [ADDR_W-1:0] IDX_CONFIG_CTRL_FW      = 20'h33464;
	localparam logic [ADDR_W-1:0] IDX_FRONTEND_A_FW       = 20'h3346E;
	localparam logic [ADDR_W-1:0] IDX_FRONTEND_B_FW       = 20'h3346F;
	localparam logic [ADDR_W-1:0] IDX_SYNC_EXT_FW         = 20'h33482;
	localparam logic [ADDR_W-1:0] IDX_POWER_CTRL_FW       = 20'h3348C;

	// word field layout
	localparam int HALF_W        = 16;
	localparam int BOOT_TYPE_LSB = 28;
	localparam int BOOT_TYPE_W   = 4;
	localparam int BOOT_VER_LSB  = 16;
	localparam int BOOT_VER_W    = 12;

	// firmware type codes
	localparam logic [HALF_W-1:0] FW_TYPE_STANDARD = 16'h0001;
	localparam logic [HALF_W-1:0] FW_TYPE_RECOVERY = 16'h0002;
	localparam logic [BOOT_TYPE_W-1:0] BOOT_TYPE_STANDARD = 4'h1;
	localparam logic [BOOT_TYPE_W-1:0] BOOT_TYPE_RECOVERY = 4'h2;

	// reset values
	localparam logic [DATA_W-1:0] WORD_RESET = 32'h00000000;
	localparam logic [HALF_W-1:0] HALF_RESET = 16'h0000;

	// axi response codes
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	typedef struct packed {
		logic [HALF_W-1:0] week;
		logic [HALF_W-1:0] year;
	} bvi_date_t;

	typedef struct packed {
		logic [HALF_W-1:0] base_pcb_rev;
		logic [HALF_W-1:0] ext_pcb_rev;
		logic [HALF_W-1:0] fe_pcb_rev;
		logic [HALF_W-1:0] base_fw_rev;
		logic [HALF_W-1:0] ext_fw_rev;
		logic [HALF_W-1:0] fe_fw_rev;
		bvi_date_t         production;
	} bvi_board_info_t;

endpackage

// ===== rtl/bvi_version_regs.sv
// read-only board and firmware identification bank behind an axi4-lite slave
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/1ps

// Summary of operation
// - board words: pcb revision high, firmware low
// - firmware words: type high, revision low
// - standard firmware reports type one
// - recovery control image reports type two
// - missing second front-end reads zero
// - missing sync extension reads zero
// - booted word: type nibble, 12-bit version
// - booted type one standard, two recovery
// - booted word low sixteen bits zero
// - production date: week high, year low
// - calibration date uses same packing
// - calibration date loaded once after reset, then changes only on factory record
module bvi_version_regs #(
	parameter logic [15:0] CTRL_FW_REV       = 16'h0001,
	parameter logic [15:0] CTRL_RECOV_FW_REV = 16'h0001,
	parameter logic [15:0] CLOCK_FW_REV      = 16'h0001,
	parameter logic [15:0] CONFIG_FW_REV     = 16'h0001,
	parameter logic [15:0] FE_A_FW_REV       = 16'h0001,
	parameter logic [15:0] FE_B_FW_REV       = 16'h0001,
	parameter logic [15:0] SYNC_EXT_FW_REV   = 16'h0001,
	parameter logic [15:0] POWER_FW_REV      = 16'h0001
) (
	input  wire logic                             aclk,
	input  wire logic                             aresetn,
	// axi4-lite write address
	input  wire logic [bvi_pkg::ADDR_W-1:0]       s_axi_awaddr,
	input  wire logic [2:0]                       s_axi_awprot,
	input  wire logic                             s_axi_awvalid,
	output logic                                  s_axi_awready,
	// axi4-lite write data
	input  wire logic [bvi_pkg::DATA_W-1:0]       s_axi_wdata,
	input  wire logic [3:0]                       s_axi_wstrb,
	input  wire logic                             s_axi_wvalid,
	output logic                                  s_axi_wready,
	// axi4-lite write response
	output logic      [1:0]                       s_axi_bresp,
	output logic                                  s_axi_bvalid,
	input  wire logic                             s_axi_bready,
	// axi4-lite read address
	input  wire logic [bvi_pkg::ADDR_W-1:0]       s_axi_araddr,
	input  wire logic [2:0]                       s_axi_arprot,
	input  wire logic                             s_axi_arvalid,
	output logic                                  s_axi_arready,
	// axi4-lite read data
	output logic      [bvi_pkg::DATA_W-1:0]       s_axi_rdata,
	output logic      [1:0]                       s_axi_rresp,
	output logic                                  s_axi_rvalid,
	input  wire logic                             s_axi_rready,
	// board straps and boot source, caught once after reset release; fitted flags followed every cycle
	input  wire bvi_pkg::bvi_board_info_t         board_info,
	input  wire logic                             frontend_b_fitted,
	input  wire logic                             sync_ext_fitted,
	input  wire logic                             recovery_booted,
	// stored calibration date and factory record strobe
	input  wire bvi_pkg::bvi_date_t               cal_date_stored,
	input  wire bvi_pkg::bvi_date_t               cal_date_new,
	input  wire logic                             factory_cal_record
);

	localparam int AW = bvi_pkg::ADDR_W;
	localparam int DW = bvi_pkg::DATA_W;

	// captured straps
	bvi_pkg::bvi_board_info_t info_r;
	logic                     captured_r;
	logic                     recovery_r;

	// identification words
	logic [DW-1:0] base_card_version_r;
	logic [DW-1:0] extension_module_version_r;
	logic [DW-1:0] frontend_module_version_r;
	logic [DW-1:0] production_date_r;
	logic [DW-1:0] factory_calibration_date_r;
	logic [DW-1:0] booted_image_info_r;
	logic [DW-1:0] main_control_fw_version;
	logic [DW-1:0] main_control_recovery_fw_version;
	logic [DW-1:0] clock_distribution_fw_version;
	logic [DW-1:0] config_controller_fw_version;
	logic [DW-1:0] frontend_a_fw_version;
	logic [DW-1:0] frontend_b_fw_version;
	logic [DW-1:0] sync_extension_fw_version;
	logic [DW-1:0] power_controller_fw_version;
	logic          cal_loaded_r;

	// bus state
	logic          aw_held_r;
	logic          w_held_r;
	logic [AW-1:0] awaddr_r;
	logic          bvalid_r;
	logic [1:0]    bresp_r;
	logic          rvalid_r;
	logic [1:0]    rresp_r;
	logic [DW-1:0] rdata_r;
	logic          aw_take;
	logic          w_take;
	logic          ar_take;
	logic          wr_go;
	logic          rd_hit;
	logic [DW-1:0] rd_word;
	logic          wr_hit;

	// straps are caught by a clocked process after release, never by the reset itself
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			info_r     <= '0;
			captured_r <= 1'b0;
		end else if (!captured_r) begin
			info_r     <= board_info;
			captured_r <= 1'b1;
		end
	end

	// boot source is fixed for the life of the image, so it is caught with the straps
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			recovery_r <= 1'b0;
		end else if (!captured_r) begin
			recovery_r <= recovery_booted;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			base_card_version_r        <= bvi_pkg::WORD_RESET;
			extension_module_version_r <= bvi_pkg::WORD_RESET;
			frontend_module_version_r  <= bvi_pkg::WORD_RESET;
		end else begin
			base_card_version_r        <= {info_r.base_pcb_rev, info_r.base_fw_rev};
			extension_module_version_r <= {info_r.ext_pcb_rev, info_r.ext_fw_rev};
			frontend_module_version_r  <= {info_r.fe_pcb_rev, info_r.fe_fw_rev};
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			production_date_r <= bvi_pkg::WORD_RESET;
		end else begin
			production_date_r <= {info_r.production.week, info_r.production.year};
		end
	end

	// the stored date is loaded once; later the strobe alone may change it
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			factory_calibration_date_r <= bvi_pkg::WORD_RESET;
			cal_loaded_r               <= 1'b0;
		end else if (factory_cal_record) begin
			factory_calibration_date_r <= {cal_date_new.week, cal_date_new.year};
			cal_loaded_r               <= 1'b1;
		end else if (!cal_loaded_r) begin
			factory_calibration_date_r <= {cal_date_stored.week, cal_date_stored.year};
			cal_loaded_r               <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			booted_image_info_r <= bvi_pkg::WORD_RESET;
		end else if (recovery_r) begin
			booted_image_info_r <= {bvi_pkg::BOOT_TYPE_RECOVERY,
				CTRL_RECOV_FW_REV[bvi_pkg::BOOT_VER_W-1:0], bvi_pkg::HALF_RESET};
		end else begin
			booted_image_info_r <= {bvi_pkg::BOOT_TYPE_STANDARD,
				CTRL_FW_REV[bvi_pkg::BOOT_VER_W-1:0], bvi_pkg::HALF_RESET};
		end
	end

	bvi_fw_word #(
		.FW_TYPE (bvi_pkg::FW_TYPE_STANDARD),
		.FW_REV  (CTRL_FW_REV)
	) u_ctrl_fw (
		.aclk    (aclk),
		.aresetn (aresetn),
		.fitted  (1'b1),
		.word_r  (main_control_fw_version)
	);

	bvi_fw_word #(
		.FW_TYPE (bvi_pkg::FW_TYPE_RECOVERY),
		.FW_REV  (CTRL_RECOV_FW_REV)
	) u_ctrl_recov_fw (
		.aclk    (aclk),
		.aresetn (aresetn),
		.fitted  (1'b1),
		.word_r  (main_control_recovery_fw_version)
	);

	bvi_fw_word #(
		.FW_TYPE (bvi_pkg::FW_TYPE_STANDARD),
		.FW_REV  (CLOCK_FW_REV)
	) u_clock_fw (
		.aclk    (aclk),
		.aresetn (aresetn),
		.fitted  (1'b1),
		.word_r  (clock_distribution_fw_version)
	);

	bvi_fw_word #(
		.FW_TYPE (bvi_pkg::FW_TYPE_STANDARD),
		.FW_REV  (CONFIG_FW_REV)
	) u_config_fw (
		.aclk    (aclk),
		.aresetn (aresetn),
		.fitted  (1'b1),
		.word_r  (config_controller_fw_version)
	);

	bvi_fw_word #(
		.FW_TYPE (bvi_pkg::FW_TYPE_STANDARD),
		.FW_REV  (FE_A_FW_REV)
	) u_fe_a_fw (
		.aclk    (aclk),
		.aresetn (aresetn),
		.fitted  (1'b1),
		.word_r  (frontend_a_fw_version)
	);

	bvi_fw_word #(
		.FW_TYPE (bvi_pkg::FW_TYPE_STANDARD),
		.FW_REV  (FE_B_FW_REV)
	) u_fe_b_fw (
		.aclk    (aclk),
		.aresetn (aresetn),
		.fitted  (frontend_b_fitted),
		.word_r  (frontend_b_fw_version)
	);

	bvi_fw_word #(
		.FW_TYPE (bvi_pkg::FW_TYPE_STANDARD),
		.FW_REV  (SYNC_EXT_FW_REV)
	) u_sync_ext_fw (
		.aclk    (aclk),
		.aresetn (aresetn),
		.fitted  (sync_ext_fitted),
		.word_r  (sync_extension_fw_version)
	);

	bvi_fw_word #(
		.FW_TYPE (bvi_pkg::FW_TYPE_STANDARD),
		.FW_REV  (POWER_FW_REV)
	) u_power_fw (
		.aclk    (aclk),
		.aresetn (aresetn),
		.fitted  (1'b1),
		.word_r  (power_controller_fw_version)
	);

	// address decode on the word index; the low two byte bits are ignored
	always_comb begin
		rd_hit  = 1'b1;
		rd_word = bvi_pkg::WORD_RESET;
		unique case (s_axi_araddr[AW-1:2])
			bvi_pkg::IDX_BASE_CARD_VERSION[AW-3:0]:  rd_word = base_card_version_r;
			bvi_pkg::IDX_EXT_MODULE_VERSION[AW-3:0]: rd_word = extension_module_version_r;
			bvi_pkg::IDX_FE_MODULE_VERSION[AW-3:0]:  rd_word = frontend_module_version_r;
			bvi_pkg::IDX_PRODUCTION_DATE[AW-3:0]:    rd_word = production_date_r;
			bvi_pkg::IDX_FACTORY_CAL_DATE[AW-3:0]:   rd_word = factory_calibration_date_r;
			bvi_pkg::IDX_MAIN_CTRL_FW[AW-3:0]:       rd_word = main_control_fw_version;
			bvi_pkg::IDX_MAIN_CTRL_RECOV_FW[AW-3:0]: rd_word = main_control_recovery_fw_version;
			bvi_pkg::IDX_BOOTED_IMAGE_INFO[AW-3:0]:  rd_word = booted_image_info_r;
			bvi_pkg::IDX_CLOCK_DIST_FW[AW-3:0]:      rd_word = clock_distribution_fw_version;
			bvi_pkg::IDX_CONFIG_CTRL_FW[AW-3:0]:     rd_word = config_controller_fw_version;
			bvi_pkg::IDX_FRONTEND_A_FW[AW-3:0]:      rd_word = frontend_a_fw_version;
			bvi_pkg::IDX_FRONTEND_B_FW[AW-3:0]:      rd_word = frontend_b_fw_version;
			bvi_pkg::IDX_SYNC_EXT_FW[AW-3:0]:        rd_word = sync_extension_fw_version;
			bvi_pkg::IDX_POWER_CTRL_FW[AW-3:0]:      rd_word = power_controller_fw_version;
			default:                                 rd_hit  = 1'b0;
		endcase
	end

	always_comb begin
		wr_hit = 1'b1;
		unique case (awaddr_r[AW-1:2])
			bvi_pkg::IDX_BASE_CARD_VERSION[AW-3:0],
			bvi_pkg::IDX_EXT_MODULE_VERSION[AW-3:0],
			bvi_pkg::IDX_FE_MODULE_VERSION[AW-3:0],
			bvi_pkg::IDX_PRODUCTION_DATE[AW-3:0],
			bvi_pkg::IDX_FACTORY_CAL_DATE[AW-3:0],
			bvi_pkg::IDX_MAIN_CTRL_FW[AW-3:0],
			bvi_pkg::IDX_MAIN_CTRL_RECOV_FW[AW-3:0],
			bvi_pkg::IDX_BOOTED_IMAGE_INFO[AW-3:0],
			bvi_pkg::IDX_CLOCK_DIST_FW[AW-3:0],
			bvi_pkg::IDX_CONFIG_CTRL_FW[AW-3:0],
			bvi_pkg::IDX_FRONTEND_A_FW[AW-3:0],
			bvi_pkg::IDX_FRONTEND_B_FW[AW-3:0],
			bvi_pkg::IDX_SYNC_EXT_FW[AW-3:0],
			bvi_pkg::IDX_POWER_CTRL_FW[AW-3:0]: wr_hit = 1'b1;
			default:                            wr_hit = 1'b0;
		endcase
	end

	// write channel: address and data taken in either order; a new write can be taken in the cycle before bvalid rises
	assign s_axi_awready = !aw_held_r && !bvalid_r;
	assign s_axi_wready  = !w_held_r && !bvalid_r;
	assign aw_take       = s_axi_awvalid && s_axi_awready;
	assign w_take        = s_axi_wvalid && s_axi_wready;
	assign wr_go         = (aw_held_r || aw_take) && (w_held_r || w_take);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r <= 1'b0;
			awaddr_r  <= '0;
		end else if (wr_go) begin
			aw_held_r <= 1'b0;
			if (aw_take) begin
				awaddr_r <= s_axi_awaddr;
			end
		end else if (aw_take) begin
			aw_held_r <= 1'b1;
			awaddr_r  <= s_axi_awaddr;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held_r <= 1'b0;
		end else if (wr_go) begin
			w_held_r <= 1'b0;
		end else if (w_take) begin
			w_held_r <= 1'b1;
		end
	end

	// the response is a cycle late because the held address is decoded after capture
	logic resp_pend_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			resp_pend_r <= 1'b0;
		end else begin
			resp_pend_r <= wr_go;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_r <= 1'b0;
			bresp_r  <= bvi_pkg::RESP_OKAY;
		end else if (resp_pend_r) begin
			bvalid_r <= 1'b1;
			bresp_r  <= wr_hit ? bvi_pkg::RESP_OKAY : bvi_pkg::RESP_DECERR;
		end else if (bvalid_r && s_axi_bready) begin
			bvalid_r <= 1'b0;
		end
	end

	// read channel: one read under way, data a cycle after the address is taken
	assign s_axi_arready = !rvalid_r;
	assign ar_take       = s_axi_arvalid && s_axi_arready;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_r <= 1'b0;
			rresp_r  <= bvi_pkg::RESP_OKAY;
			rdata_r  <= bvi_pkg::WORD_RESET;
		end else if (ar_take) begin
			rvalid_r <= 1'b1;
			rresp_r  <= rd_hit ? bvi_pkg::RESP_OKAY : bvi_pkg::RESP_DECERR;
			rdata_r  <= rd_word;
		end else if (rvalid_r && s_axi_rready) begin
			rvalid_r <= 1'b0;
		end
	end

	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp  = bresp_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rresp  = rresp_r;
	assign s_axi_rdata  = rdata_r;

endmodule

// ===== verification/bvi_version_regs_bench.sv
// self-checking bench for the version information bank
`timescale 1ns/1ps
module bvi_version_regs_bench;
	localparam logic [15:0] CREV = 16'h0A5C;
	localparam logic [15:0] GREV = 16'h0B3E;
	localparam logic [15:0] KREV = 16'h0012;
	localparam logic [15:0] NREV = 16'h0023;
	localparam logic [15:0] AREV = 16'h0034;
	localparam logic [15:0] BREV = 16'h0045;
	localparam logic [15:0] SREV = 16'h0056;
	localparam logic [15:0] PREV = 16'h0067;
	localparam logic [15:0] STD  = bvi_pkg::FW_TYPE_STANDARD;
	localparam logic [1:0]  DE   = bvi_pkg::RESP_DECERR;
	logic                     aclk;
	logic                     aresetn;
	logic [19:0]              awaddr;
	logic [19:0]              araddr;
	logic [31:0]              wdata;
	logic [31:0]              rdata;
	logic [31:0]              rd_q;
	logic [1:0]               bresp;
	logic [1:0]               rresp;
	logic [1:0]               rs_q;
	logic                     awvalid;
	logic                     awready;
	logic                     wvalid;
	logic                     wready;
	logic                     bvalid;
	logic                     bready;
	logic                     arvalid;
	logic                     arready;
	logic                     rvalid;
	logic                     rready;
	logic                     feb;
	logic                     sxt;
	logic                     recov;
	logic                     rec;
	bvi_pkg::bvi_board_info_t info;
	bvi_pkg::bvi_date_t       cal_old;
	bvi_pkg::bvi_date_t       cal_new;
	int                       n_fail;
	int                       checks;

	bvi_version_regs #(.CTRL_FW_REV(CREV), .CTRL_RECOV_FW_REV(GREV), .CLOCK_FW_REV(KREV),
		.CONFIG_FW_REV(NREV), .FE_A_FW_REV(AREV), .FE_B_FW_REV(BREV),
		.SYNC_EXT_FW_REV(SREV), .POWER_FW_REV(PREV)) dut (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .board_info(info),
		.frontend_b_fitted(feb), .sync_ext_fitted(sxt), .recovery_booted(recov),
		.cal_date_stored(cal_old), .cal_date_new(cal_new), .factory_cal_record(rec));

	initial aclk = 1'b0;
	always #50 aclk = ~aclk;

	task automatic tally_and_finish();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic hung();
		n_fail++;
		tally_and_finish();
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
			n_fail++;
		end
	endtask
	// ready is combinational from state, so it is sampled mid-cycle
	task automatic rd(input logic [19:0] idx, input logic [31:0] exp,
		input logic [1:0] er = bvi_pkg::RESP_OKAY);
		int  i;
		logic hs;
		@(posedge aclk);
		araddr <= {idx[17:0], 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		hs = 1'b0;
		for (i = 0; i < 40 && !hs; i++) begin
			@(negedge aclk);
			hs = (arready === 1'b1);
			@(posedge aclk);
		end
		arvalid <= 1'b0;
		if (!hs)
			hung();
		hs = 1'b0;
		for (i = 0; i < 40 && !hs; i++) begin
			@(negedge aclk);
			hs = (rvalid === 1'b1);
			rd_q = rdata;
			rs_q = rresp;
			@(posedge aclk);
		end
		rready <= 1'b0;
		if (!hs)
			hung();
		chk(rd_q, exp);
		chk({30'h0, rs_q}, {30'h0, er});
	endtask
	task automatic wr(input logic [19:0] idx, input logic [31:0] d, input logic [1:0] er);
		int  i;
		logic a;
		logic w;
		logic hs;
		@(posedge aclk);
		awaddr <= {idx[17:0], 2'b00};
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		a = 1'b0;
		w = 1'b0;
		for (i = 0; i < 40 && !(a && w); i++) begin
			@(negedge aclk);
			a = a || (awvalid && awready === 1'b1);
			w = w || (wvalid && wready === 1'b1);
			@(posedge aclk);
			awvalid <= awvalid && !a;
			wvalid <= wvalid && !w;
		end
		hs = 1'b0;
		for (i = 0; i < 40 && !hs && a && w; i++) begin
			@(negedge aclk);
			hs = (bvalid === 1'b1);
			rs_q = bresp;
			@(posedge aclk);
		end
		bready <= 1'b0;
		if (!hs)
			hung();
		chk({30'h0, rs_q}, {30'h0, er});
	endtask
	task automatic do_reset();
		aresetn <= 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (3) @(posedge aclk);
	endtask

	initial begin
		n_fail = 0;
		checks = 0;
		{awvalid, wvalid, bready, arvalid, rready, rec} <= 6'h00;
		{awaddr, araddr, wdata} <= 72'h0;
		info <= {16'h1101, 16'h2202, 16'h3303, 16'h4404, 16'h5505, 16'h6606, 16'h0017, 16'h07E4};
		{feb, sxt, recov} <= 3'h0;
		cal_old <= {16'h0009, 16'h07E3};
		cal_new <= {16'h0030, 16'h07E5};
		do_reset();
		// identification words after power-up
		rd(bvi_pkg::IDX_BASE_CARD_VERSION, {info.base_pcb_rev, info.base_fw_rev});
		rd(bvi_pkg::IDX_EXT_MODULE_VERSION, {info.ext_pcb_rev, info.ext_fw_rev});
		rd(bvi_pkg::IDX_FE_MODULE_VERSION, {info.fe_pcb_rev, info.fe_fw_rev});
		rd(bvi_pkg::IDX_PRODUCTION_DATE, info.production);
		rd(bvi_pkg::IDX_FACTORY_CAL_DATE, cal_old);
		rd(bvi_pkg::IDX_MAIN_CTRL_FW, {STD, CREV});
		rd(bvi_pkg::IDX_MAIN_CTRL_RECOV_FW, {bvi_pkg::FW_TYPE_RECOVERY, GREV});
		rd(bvi_pkg::IDX_BOOTED_IMAGE_INFO, {4'h1, CREV[11:0], 16'h0000});
		rd(bvi_pkg::IDX_CLOCK_DIST_FW, {STD, KREV});
		rd(bvi_pkg::IDX_CONFIG_CTRL_FW, {STD, NREV});
		rd(bvi_pkg::IDX_FRONTEND_A_FW, {STD, AREV});
		rd(bvi_pkg::IDX_POWER_CTRL_FW, {STD, PREV});
		rd(bvi_pkg::IDX_FRONTEND_B_FW, 32'h00000000);
		rd(bvi_pkg::IDX_SYNC_EXT_FW, 32'h00000000);
		// optional modules fitted
		feb <= 1'b1;
		sxt <= 1'b1;
		rd(bvi_pkg::IDX_FRONTEND_B_FW, {STD, BREV});
		rd(bvi_pkg::IDX_SYNC_EXT_FW, {STD, SREV});
		// writes are answered but change nothing
		wr(bvi_pkg::IDX_BASE_CARD_VERSION, 32'hFFFFFFFF, bvi_pkg::RESP_OKAY);
		rd(bvi_pkg::IDX_BASE_CARD_VERSION, {info.base_pcb_rev, info.base_fw_rev});
		wr(bvi_pkg::IDX_FACTORY_CAL_DATE, 32'h12345678, bvi_pkg::RESP_OKAY);
		rd(bvi_pkg::IDX_FACTORY_CAL_DATE, cal_old);
		wr(20'h00100, 32'h00000001, DE);
		rd(20'h00100, 32'h00000000, DE);
		// factory record replaces the calibration date
		rec <= 1'b1;
		@(posedge aclk);
		rec <= 1'b0;
		rd(bvi_pkg::IDX_FACTORY_CAL_DATE, cal_new);
		// recovery image booted after a second reset
		{feb, sxt, recov} <= 3'h1;
		info.production <= {16'h0033, 16'h07E6};
		do_reset();
		rd(bvi_pkg::IDX_BOOTED_IMAGE_INFO, {4'h2, GREV[11:0], 16'h0000});
		rd(bvi_pkg::IDX_PRODUCTION_DATE, info.production);
		rd(bvi_pkg::IDX_MAIN_CTRL_RECOV_FW, {bvi_pkg::FW_TYPE_RECOVERY, GREV});
		rd(bvi_pkg::IDX_FRONTEND_B_FW, 32'h00000000);
		rd(bvi_pkg::IDX_SYNC_EXT_FW, 32'h00000000);
		tally_and_finish();
	end
endmodule

// ===== verification/bvi_version_regs_properties.sv
// assertion checker for the version information bank
`timescale 1ns/1ps
module bvi_version_regs_properties (
	input wire logic                       aclk,
	input wire logic                       aresetn,
	input wire logic [bvi_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic                       s_axi_arvalid,
	input wire logic                       s_axi_arready,
	input wire logic [bvi_pkg::DATA_W-1:0] s_axi_rdata,
	input wire logic [1:0]                 s_axi_rresp,
	input wire logic                       s_axi_rvalid,
	input wire bvi_pkg::bvi_board_info_t   board_info,
	input wire logic                       frontend_b_fitted,
	input wire logic                       sync_ext_fitted,
	input wire logic                       recovery_booted
);
	logic [17:0] idx_q;
	logic [1:0]  rel_q;
	logic        ok;
	// read data settles three edges after release, so earlier data is not judged
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rel_q <= 2'h0;
		end else if (rel_q != 2'h3) begin
			rel_q <= rel_q + 2'h1;
		end
	end
	always_ff @(posedge aclk) begin
		if (s_axi_arvalid && s_axi_arready) begin
			idx_q <= s_axi_araddr[19:2];
		end
	end
	assign ok = s_axi_rvalid && rel_q == 2'h3 && s_axi_rresp == bvi_pkg::RESP_OKAY;
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	a_base_word_halves: assert property (
		ok && idx_q == bvi_pkg::IDX_BASE_CARD_VERSION[17:0]
		|-> s_axi_rdata == {board_info.base_pcb_rev, board_info.base_fw_rev})
		else $error("base card word halves wrong");
	a_main_std_type: assert property (
		s_axi_arvalid && s_axi_arready && rel_q[1]
		&& s_axi_araddr[19:2] == bvi_pkg::IDX_MAIN_CTRL_FW[17:0]
		|=> s_axi_rvalid && s_axi_rdata[31:16] == 16'h0001)
		else $error("main control type not one");
	a_recov_type_two: assert property (
		ok && idx_q == bvi_pkg::IDX_MAIN_CTRL_RECOV_FW[17:0] |-> s_axi_rdata[31:16] == 16'h0002)
		else $error("recovery type not two");
	a_feb_absent_zero: assert property (
		ok && idx_q == bvi_pkg::IDX_FRONTEND_B_FW[17:0] && !$past(frontend_b_fitted)
		&& !$past(frontend_b_fitted, 2) && !$past(frontend_b_fitted, 3)
		|-> s_axi_rdata == 32'h00000000)
		else $error("absent front-end b word not zero");
	a_sync_absent_zero: assert property (
		ok && idx_q == bvi_pkg::IDX_SYNC_EXT_FW[17:0] && !$past(sync_ext_fitted)
		&& !$past(sync_ext_fitted, 2) && !$past(sync_ext_fitted, 3)
		|-> s_axi_rdata == 32'h00000000)
		else $error("absent extension word not zero");
	a_boot_type_code: assert property (
		ok && idx_q == bvi_pkg::IDX_BOOTED_IMAGE_INFO[17:0]
		|-> s_axi_rdata[31:28] == (recovery_booted ? 4'h2 : 4'h1))
		else $error("booted type nibble wrong");
	a_boot_low_zero: assert property (
		ok && idx_q == bvi_pkg::IDX_BOOTED_IMAGE_INFO[17:0] |-> s_axi_rdata[15:0] == 16'h0000)
		else $error("booted low half not zero");
	a_prod_date_pack: assert property (
		ok && idx_q == bvi_pkg::IDX_PRODUCTION_DATE[17:0] |-> s_axi_rdata == board_info.production)
		else $error("production date packing wrong");
	c_boot_read: cover property (ok && idx_q == bvi_pkg::IDX_BOOTED_IMAGE_INFO[17:0]);
	c_decerr: cover property (s_axi_rvalid && s_axi_rresp == bvi_pkg::RESP_DECERR);
	c_recov_boot: cover property (ok && recovery_booted);
endmodule

bind bvi_version_regs bvi_version_regs_properties u_props (
	.aclk,
	.aresetn,
	.s_axi_araddr,
	.s_axi_arvalid,
	.s_axi_arready,
	.s_axi_rdata,
	.s_axi_rresp,
	.s_axi_rvalid,
	.board_info,
	.frontend_b_fitted,
	.sync_ext_fitted,
	.recovery_booted
);
